// [cbx_pkg.sv]
package cbx_pkg;

	localparam int CBX_ADDR_W = 12;
	localparam int CBX_PC_W = 16;

	// Register byte offsets
	localparam logic [11:0] CBX_CMD_OFS = 12'h000;
	localparam logic [11:0] CBX_STAT_OFS = 12'h004;
	localparam logic [11:0] CBX_PC_OFS = 12'h008;
	localparam logic [11:0] CBX_FLAGS_OFS = 12'h00c;
	localparam logic [11:0] CBX_GPR_BASE = 12'h100;
	localparam logic [11:0] CBX_IO_BASE = 12'h200;
	localparam logic [11:0] CBX_WIN_MASK = 12'hf80;

	// Status register bits
	localparam int CBX_STAT_BUSY = 0;
	localparam int CBX_STAT_ERR = 1;
	localparam int CBX_STAT_TAKEN = 2;

	// Status flag register bit positions
	localparam logic [2:0] CBX_FLG_C = 3'h0;
	localparam logic [2:0] CBX_FLG_Z = 3'h1;
	localparam logic [2:0] CBX_FLG_N = 3'h2;
	localparam logic [2:0] CBX_FLG_V = 3'h3;
	localparam logic [2:0] CBX_FLG_S = 3'h4;
	localparam logic [2:0] CBX_FLG_H = 3'h5;
	localparam logic [2:0] CBX_FLG_T = 3'h6;
	localparam logic [2:0] CBX_FLG_I = 3'h7;

	// Highest bit-addressable I/O location
	localparam logic [5:0] CBX_IO_BIT_MAX = 6'h1f;

	// Cycle counts
	localparam logic [1:0] CBX_CYC_ONE = 2'h1;
	localparam logic [1:0] CBX_CYC_TWO = 2'h2;
	localparam logic [1:0] CBX_CYC_THREE = 2'h3;

	// Reset values
	localparam logic [15:0] CBX_PC_RST = 16'h0000;
	localparam logic [7:0] CBX_FLAGS_RST = 8'h00;
	localparam logic [7:0] CBX_BYTE_RST = 8'h00;

	typedef enum logic [4:0] {
		CBX_OP_NOP,
		CBX_OP_SKIP_REG_CLR,
		CBX_OP_SKIP_REG_SET,
		CBX_OP_SKIP_IO_CLR,
		CBX_OP_SKIP_IO_SET,
		CBX_OP_BR_FLAG_SET,
		CBX_OP_BR_FLAG_CLR,
		CBX_OP_BR_GE,
		CBX_OP_BR_LT,
		CBX_OP_IO_FORCE_ONE,
		CBX_OP_IO_FORCE_ZERO,
		CBX_OP_SHL,
		CBX_OP_SHR,
		CBX_OP_ROL,
		CBX_OP_ROR,
		CBX_OP_ASR,
		CBX_OP_BIT_TO_T,
		CBX_OP_T_TO_BIT,
		CBX_OP_FLAG_ONE,
		CBX_OP_FLAG_ZERO
	} cbx_op_t;

	// Command word layout
	typedef struct packed {
		logic [6:0] k;
		logic [2:0] pad0;
		logic [5:0] addr;
		logic [3:0] pad1;
		logic two_word;
		logic [2:0] bitsel;
		logic [2:0] pad2;
		logic [4:0] op;
	} cbx_cmd_t;

	typedef struct packed {
		logic [7:0] value;
		logic c;
		logic z;
		logic n;
		logic v;
	} cbx_shift_res_t;

endpackage

// [cbx_shift_unit.sv]
module cbx_shift_unit
	import cbx_pkg::*;
(
	input wire logic [4:0] op,
	input wire logic [7:0] value,
	input wire logic carry_in,
	output cbx_shift_res_t res
);

	logic [7:0] shl_v;
	logic [7:0] shr_v;
	logic [7:0] rol_v;
	logic [7:0] ror_v;
	logic [7:0] asr_v;
	logic [7:0] out_v;
	logic out_c;

	assign shl_v = {value[6:0], 1'b0};
	assign rol_v = {value[6:0], carry_in};
	assign shr_v = {1'b0, value[7:1]};
	assign ror_v = {carry_in, value[7:1]};
	assign asr_v = {value[7], value[7:1]};

	assign out_v = (op == CBX_OP_SHL) ? shl_v :
		(op == CBX_OP_ROL) ? rol_v :
		(op == CBX_OP_SHR) ? shr_v :
		(op == CBX_OP_ROR) ? ror_v :
		asr_v;
	assign out_c = ((op == CBX_OP_SHL) || (op == CBX_OP_ROL)) ? value[7] : value[0];

	assign res.value = out_v;
	assign res.c = out_c;
	assign res.z = (out_v == 8'h00);
	assign res.n = out_v[7];
	assign res.v = out_v[7] ^ out_c;

endmodule

// [cbx_cond_unit.sv]
module cbx_cond_unit
	import cbx_pkg::*;
(
	input wire logic [4:0] op,
	input wire logic [2:0] bitsel,
	input wire logic [7:0] flags,
	input wire logic [7:0] gpr_value,
	input wire logic [7:0] io_value,
	output logic taken
);

	logic gpr_bit;
	logic io_bit;
	logic flag_bit;
	logic signed_lt;

	assign gpr_bit = gpr_value[bitsel];
	assign io_bit = io_value[bitsel];
	assign flag_bit = flags[bitsel];
	assign signed_lt = flags[CBX_FLG_N] ^ flags[CBX_FLG_V];

	always_comb
	begin
		case (op)
			CBX_OP_SKIP_REG_CLR: taken = !gpr_bit;
			CBX_OP_SKIP_REG_SET: taken = gpr_bit;
			CBX_OP_SKIP_IO_CLR: taken = !io_bit;
			CBX_OP_SKIP_IO_SET: taken = io_bit;
			CBX_OP_BR_FLAG_SET: taken = flag_bit;
			CBX_OP_BR_FLAG_CLR: taken = !flag_bit;
			CBX_OP_BR_GE: taken = !signed_lt;
			CBX_OP_BR_LT: taken = signed_lt;
			default: taken = 1'b0;
		endcase
	end

endmodule

// [cbx_exec.sv]
module cbx_exec
	import cbx_pkg::*;
#(
	parameter int GPR_DEPTH = 32,
	parameter int IO_DEPTH = 32
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CBX_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy
);

	typedef enum logic {
		CBX_ST_IDLE,
		CBX_ST_EXEC
	} cbx_state_t;

	if (GPR_DEPTH != 32 || IO_DEPTH != 32)
	begin : g_depth_check
		$error("cbx_exec: depths other than 32 are not supported");
	end

	function automatic logic in_win(input logic [CBX_ADDR_W-1:0] a, input logic [11:0] base);
		in_win = ((a & CBX_WIN_MASK) == base) && (a[1:0] == 2'h0);
	endfunction

	cbx_state_t state_q;
	logic [1:0] cnt_q;
	cbx_cmd_t cmd_q;
	logic [15:0] pc_q;
	logic [7:0] flags_q;
	logic err_q;
	logic taken_q;
	logic [7:0] gpr_q [GPR_DEPTH];
	logic [7:0] io_q [IO_DEPTH];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// APB decode
	logic acc;
	logic acc_new;
	logic wr_fire;
	logic hit_cmd;
	logic hit_stat;
	logic hit_pc;
	logic hit_flags;
	logic hit_gpr;
	logic hit_io;
	logic mapped;
	logic [4:0] win_idx;
	logic cmd_bad_io;
	logic bad_acc;

	assign acc = psel && penable;
	assign acc_new = acc && !pready_q;
	assign hit_cmd = (paddr == CBX_CMD_OFS);
	assign hit_stat = (paddr == CBX_STAT_OFS);
	assign hit_pc = (paddr == CBX_PC_OFS);
	assign hit_flags = (paddr == CBX_FLAGS_OFS);
	assign hit_gpr = in_win(paddr, CBX_GPR_BASE);
	assign hit_io = in_win(paddr, CBX_IO_BASE);
	assign mapped = hit_cmd || hit_stat || hit_pc || hit_flags || hit_gpr || hit_io;
	assign win_idx = paddr[6:2];

	// Current command: fresh write while idle, latched while executing
	cbx_cmd_t cur;
	logic [4:0] cur_op;
	logic is_io_op;
	logic is_skip;
	logic is_branch;
	assign cur = (state_q == CBX_ST_IDLE) ? cbx_cmd_t'(pwdata) : cmd_q;
	assign cur_op = cur.op;
	assign is_io_op = (cur_op == CBX_OP_SKIP_IO_CLR) || (cur_op == CBX_OP_SKIP_IO_SET)
		|| (cur_op == CBX_OP_IO_FORCE_ONE) || (cur_op == CBX_OP_IO_FORCE_ZERO);
	assign is_skip = (cur_op >= CBX_OP_SKIP_REG_CLR) && (cur_op <= CBX_OP_SKIP_IO_SET);
	assign is_branch = (cur_op >= CBX_OP_BR_FLAG_SET) && (cur_op <= CBX_OP_BR_LT);
	assign cmd_bad_io = is_io_op && (cur.addr > CBX_IO_BIT_MAX);
	assign bad_acc = !mapped || (pwrite && state_q != CBX_ST_IDLE && !hit_stat)
		|| (pwrite && hit_cmd && cmd_bad_io);
	assign wr_fire = acc && pready_q && pwrite && !pslverr_q;

	// Operand fetch
	logic [7:0] gpr_val;
	logic [7:0] io_val;
	logic cond_taken;
	cbx_shift_res_t sh;
	assign gpr_val = gpr_q[cur.addr[4:0]];
	assign io_val = io_q[cur.addr[4:0]];

	cbx_cond_unit u_cond (
		.op(cur_op),
		.bitsel(cur.bitsel),
		.flags(flags_q),
		.gpr_value(gpr_val),
		.io_value(io_val),
		.taken(cond_taken)
	);

	cbx_shift_unit u_shift (
		.op(cur_op),
		.value(gpr_val),
		.carry_in(flags_q[CBX_FLG_C]),
		.res(sh)
	);

	// Cycle count of the command
	logic [1:0] cyc;
	assign cyc = (is_skip && cond_taken) ? (cur.two_word ? CBX_CYC_THREE : CBX_CYC_TWO) :
		(is_branch && cond_taken) ? CBX_CYC_TWO :
		(cur_op == CBX_OP_IO_FORCE_ONE || cur_op == CBX_OP_IO_FORCE_ZERO) ? CBX_CYC_TWO :
		CBX_CYC_ONE;

	// Program counter next value
	logic [15:0] k_ext;
	logic [15:0] pc_next;
	assign k_ext = {{9{cur.k[6]}}, cur.k};
	assign pc_next = (is_skip && cond_taken) ? pc_q + {14'h0000, cyc} :
		(is_branch && cond_taken) ? pc_q + k_ext + 16'h0001 :
		pc_q + 16'h0001;

	// Flag register next value
	logic is_shift;
	logic [7:0] flags_next;
	logic [7:0] flag_onehot;
	assign is_shift = (cur_op >= CBX_OP_SHL) && (cur_op <= CBX_OP_ASR);
	assign flag_onehot = 8'h01 << cur.bitsel;

	always_comb
	begin
		flags_next = flags_q;
		if (is_shift)
		begin
			flags_next[CBX_FLG_Z] = sh.z;
			flags_next[CBX_FLG_C] = sh.c;
			flags_next[CBX_FLG_N] = sh.n;
			flags_next[CBX_FLG_V] = sh.v;
		end
		else if (cur_op == CBX_OP_BIT_TO_T)
			flags_next[CBX_FLG_T] = gpr_val[cur.bitsel];
		else if (cur_op == CBX_OP_FLAG_ONE)
			flags_next = flags_q | flag_onehot;
		else if (cur_op == CBX_OP_FLAG_ZERO)
			flags_next = flags_q & ~flag_onehot;
	end

	// Register file next value
	logic gpr_we;
	logic [7:0] gpr_wval;
	logic io_we;
	logic [7:0] io_wval;
	assign gpr_we = is_shift || (cur_op == CBX_OP_T_TO_BIT);
	assign gpr_wval = is_shift ? sh.value :
		((gpr_val & ~flag_onehot) | ({8{flags_q[CBX_FLG_T]}} & flag_onehot));
	assign io_we = (cur_op == CBX_OP_IO_FORCE_ONE) || (cur_op == CBX_OP_IO_FORCE_ZERO);
	assign io_wval = (cur_op == CBX_OP_IO_FORCE_ONE) ? (io_val | flag_onehot) :
		(io_val & ~flag_onehot);

	// Execution control
	logic start;
	logic finish;
	assign start = wr_fire && hit_cmd && (state_q == CBX_ST_IDLE);
	assign finish = (state_q == CBX_ST_EXEC) && (cnt_q == CBX_CYC_ONE);

	// Read mux
	logic [31:0] rd_mux;
	assign rd_mux = hit_cmd ? 32'(cmd_q) :
		hit_stat ? {29'h0, taken_q, err_q, state_q == CBX_ST_EXEC} :
		hit_pc ? {16'h0000, pc_q} :
		hit_flags ? {24'h000000, flags_q} :
		hit_gpr ? {24'h000000, gpr_q[win_idx]} :
		hit_io ? {24'h000000, io_q[win_idx]} :
		32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= acc_new;
			pslverr_q <= acc_new && bad_acc;
			if (acc_new)
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= CBX_ST_IDLE;
			cnt_q <= CBX_CYC_ONE;
			cmd_q <= '0;
			taken_q <= 1'b0;
		end
		else if (start)
		begin
			state_q <= CBX_ST_EXEC;
			cnt_q <= cyc;
			cmd_q <= cur;
			taken_q <= 1'b0;
		end
		else if (finish)
		begin
			state_q <= CBX_ST_IDLE;
			taken_q <= cond_taken;
		end
		else if (state_q == CBX_ST_EXEC)
			cnt_q <= cnt_q - 2'h1;
	end

	// Error flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_q <= 1'b0;
		else if (acc_new && pwrite && hit_cmd && cmd_bad_io)
			err_q <= 1'b1;
		else if (wr_fire && hit_stat && pwdata[CBX_STAT_ERR])
			err_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_q <= CBX_PC_RST;
			flags_q <= CBX_FLAGS_RST;
		end
		else if (finish)
		begin
			pc_q <= pc_next;
			flags_q <= flags_next;
		end
		else if (wr_fire && hit_pc)
			pc_q <= pwdata[15:0];
		else if (wr_fire && hit_flags)
			flags_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < GPR_DEPTH; i++)
				gpr_q[i] <= CBX_BYTE_RST;
		end
		else if (finish && gpr_we)
			gpr_q[cmd_q.addr[4:0]] <= gpr_wval;
		else if (wr_fire && hit_gpr)
			gpr_q[win_idx] <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < IO_DEPTH; i++)
				io_q[i] <= CBX_BYTE_RST;
		end
		else if (finish && io_we)
			io_q[cmd_q.addr[4:0]] <= io_wval;
		else if (wr_fire && hit_io)
			io_q[win_idx] <= pwdata[7:0];
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign busy = (state_q == CBX_ST_EXEC);

endmodule

// [cbx_exec_chk.sv]
module cbx_exec_chk
	import cbx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CBX_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic cmd_w = psel && penable && pwrite && pready && paddr == CBX_CMD_OFS;
	wire logic ok = cmd_w && !pslverr;
	wire logic [4:0] op = pwdata[4:0];
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not after one wait");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_io_range_refused: assert property (cmd_w && op inside {3, 4, 9, 10} && pwdata[21] |-> pslverr)
		else $error("io command above range accepted");
	a_force_two_cyc: assert property (ok && op inside {9, 10} |=> busy [*2] ##1 !busy)
		else $error("io bit force not two cycles");
	a_shift_one_cyc: assert property (ok && op inside {[11:15]} |=> busy ##1 !busy)
		else $error("shift not one cycle");
	a_tbit_one_cyc: assert property (ok && op inside {16, 17} |=> busy ##1 !busy)
		else $error("transfer bit op not one cycle");
	a_flag_one_cyc: assert property (ok && op inside {18, 19} |=> busy ##1 !busy)
		else $error("flag op not one cycle");
	a_skip_bound: assert property (ok && op inside {[1:4]} |=> busy ##[1:3] !busy)
		else $error("skip length out of range");
	a_branch_bound: assert property (ok && op inside {[5:8]} |=> busy ##[1:2] !busy)
		else $error("branch length out of range");
endmodule

bind cbx_exec cbx_exec_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// [cbx_exec_test.sv]
module cbx_exec_test
	import cbx_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [CBX_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, busy, err;
	logic [7:0] f = 8'h00;
	logic [15:0] pc = 16'h0000;
	int n_fail = 0;
	int compares = 0;
	always #50 pclk = ~pclk;
	cbx_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busy(busy));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] cmd(input logic [4:0] op, input logic [2:0] b,
		input logic [5:0] a, input logic tw, input logic [6:0] k);
		cmd = {k, 3'h0, a, 4'h0, tw, b, 3'h0, op};
	endfunction
	task automatic run(input logic [31:0] c, input string what);
		apb(1'b1, CBX_CMD_OFS, c);
		do
			apb(1'b0, CBX_STAT_OFS, 32'h0);
		while (rd[0] !== 1'b0);
		apb(1'b0, CBX_PC_OFS, 32'h0);
		check({what, " pc"}, rd, {16'h0, pc});
		apb(1'b0, CBX_FLAGS_OFS, 32'h0);
		check({what, " flags"}, rd, {24'h0, f});
	endtask
	task automatic t_flags();
		for (int i = 0; i < 16; i++)
		begin
			f[i[2:0]] = (i < 8);
			pc++;
			run(cmd((i < 8) ? 5'd18 : 5'd19, i[2:0], 6'h0, 1'b0, 7'h0), "flag");
		end
	endtask
	task automatic t_branch();
		logic [6:0] k;
		logic tk;
		for (int i = 0; i < 4; i++)
		begin
			f[2 * i] = 1'b1;
			pc++;
			run(cmd(5'd18, 3'(2 * i), 6'h0, 1'b0, 7'h0), "flag");
		end
		for (int j = 0; j < 20; j++)
		begin
			if (j == 18)
			begin
				f[2] = 1'b0;
				pc++;
				run(cmd(5'd19, 3'd2, 6'h0, 1'b0, 7'h0), "flag");
			end
			k = j[1] ? 7'h7c : 7'h05;
			tk = ((j < 16) ? f[j[3:1]] : (f[2] ^ f[3])) ^ j[0] ^ (j >= 16);
			pc = tk ? pc + {{9{k[6]}}, k} + 16'h1 : pc + 16'h1;
			run(cmd((j < 16) ? 5'(5 + j[0]) : 5'(7 + j[0]), j[3:1], 6'h0, 1'b0, k), "branch");
		end
	endtask
	function automatic logic [8:0] sh(input int op, input logic [7:0] v, input logic c);
		case (op)
			11: sh = {v[7], v[6:0], 1'b0};
			12: sh = {v[0], 1'b0, v[7:1]};
			13: sh = {v[7], v[6:0], c};
			14: sh = {v[0], c, v[7:1]};
			default: sh = {v[0], v[7], v[7:1]};
		endcase
	endfunction
	task automatic t_shift();
		logic [7:0] vals[2] = '{8'h81, 8'h01};
		logic [7:0] r;
		foreach (vals[n])
			for (int op = 11; op < 16; op++)
			begin
				apb(1'b1, CBX_GPR_BASE + 12'h00c, {24'h0, vals[n]});
				{f[0], r} = sh(op, vals[n], f[0]);
				f[1] = (r == 8'h00);
				f[2] = r[7];
				f[3] = r[7] ^ f[0];
				pc++;
				run(cmd(5'(op), 3'd0, 6'h03, 1'b0, 7'h0), "shift");
				apb(1'b0, CBX_GPR_BASE + 12'h00c, 32'h0);
				check("shift value", rd, {24'h0, r});
			end
	endtask
	task automatic t_bits();
		apb(1'b1, CBX_GPR_BASE + 12'h010, 32'h24);
		f[6] = 1'b0;
		pc++;
		run(cmd(5'd16, 3'd1, 6'h04, 1'b0, 7'h0), "bit to t");
		pc++;
		run(cmd(5'd17, 3'd5, 6'h04, 1'b0, 7'h0), "t to bit");
		apb(1'b0, CBX_GPR_BASE + 12'h010, 32'h0);
		check("t to bit value", rd, 32'h04);
		pc += 3;
		run(cmd(5'd2, 3'd2, 6'h04, 1'b1, 7'h0), "skip two");
		pc += 1;
		run(cmd(5'd1, 3'd2, 6'h04, 1'b1, 7'h0), "no skip");
		pc += 2;
		run(cmd(5'd1, 3'd1, 6'h04, 1'b0, 7'h0), "skip one");
	endtask
	task automatic t_io();
		apb(1'b1, CBX_IO_BASE + 12'h014, 32'ha5);
		pc++;
		run(cmd(5'd9, 3'd1, 6'h05, 1'b0, 7'h0), "io one");
		pc++;
		run(cmd(5'd10, 3'd0, 6'h05, 1'b0, 7'h0), "io zero");
		apb(1'b0, CBX_IO_BASE + 12'h014, 32'h0);
		check("io byte", rd, 32'ha6);
		pc += 3;
		run(cmd(5'd4, 3'd1, 6'h05, 1'b1, 7'h0), "io skip");
		apb(1'b0, CBX_STAT_OFS, 32'h0);
		check("status taken", rd, 32'h4);
		pc += 1;
		run(cmd(5'd3, 3'd1, 6'h05, 1'b1, 7'h0), "io no skip");
		apb(1'b1, CBX_CMD_OFS, cmd(5'd9, 3'd1, 6'h20, 1'b0, 7'h0));
		check("io range err", {31'h0, err}, 32'h1);
		apb(1'b0, CBX_PC_OFS, 32'h0);
		check("pc after refusal", rd, {16'h0, pc});
		apb(1'b0, CBX_STAT_OFS, 32'h0);
		check("status err", rd, 32'h2);
		apb(1'b1, CBX_STAT_OFS, 32'h2);
		apb(1'b0, CBX_STAT_OFS, 32'h0);
		check("status cleared", rd, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#2000000;
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_flags();
		t_branch();
		t_shift();
		t_bits();
		t_io();
		tally_and_finish();
	end
endmodule
